//--- logic/stap_top.sv
// Test access port front end: controller, instruction, bypass, identification
// and boundary scan registers, all stepped by edges of a sampled test clock.
// Assumes tck, tms and tdi come from pins outside the clk domain.
`include "stap_regs.svh"
`default_nettype none

module stap_top #(
	parameter logic [`STAP_ID_W-1:0] ID_CODE = 32'h0000_0001 // Arbitrary value.
) (
	input wire logic clk,
	input wire logic nrst,
	input wire stap_pkg::stap_pins_t pins,
	input wire logic tms_driven,
	input wire logic tdi_driven,
	input wire logic [`STAP_BSR_W-1:0] bsr_capture,
	output logic tdo,
	output logic tdo_oe,
	output logic out_hiz
);

	// ----------------------------------------
	// Reset and pin synchronisers
	// ----------------------------------------
	logic rst_s1_ff, rst_n_ff;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff <= rst_s1_ff;
		end
	end

	stap_pkg::stap_pins_t pin_raw, pin_s1_ff, pin_s2_ff;
	logic tck_d_ff;
	always_comb begin
		pin_raw = pins;
		pin_raw.tms = tms_driven ? pins.tms : 1'b1;
		pin_raw.tdi = tdi_driven ? pins.tdi : 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			tck_d_ff <= 1'b0;
		end else begin
			pin_s1_ff <= pin_raw;
			pin_s2_ff <= pin_s1_ff;
			tck_d_ff <= pin_s2_ff.tck;
		end
	end

	// A test clock held low yields no edges, so nothing below ever moves.
	logic tck_rise, tck_fall;
	assign tck_rise = pin_s2_ff.tck & ~tck_d_ff;
	assign tck_fall = ~pin_s2_ff.tck & tck_d_ff;

	// ----------------------------------------
	// Controller
	// ----------------------------------------
	function automatic stap_pkg::stap_state_t step(input stap_pkg::stap_state_t s,
		input logic m);
		unique case (s)
			stap_pkg::ST_TLR: step = m ? stap_pkg::ST_TLR : stap_pkg::ST_RTI;
			stap_pkg::ST_RTI: step = m ? stap_pkg::ST_SEL_DR : stap_pkg::ST_RTI;
			stap_pkg::ST_SEL_DR: step = m ? stap_pkg::ST_SEL_IR : stap_pkg::ST_CAP_DR;
			stap_pkg::ST_CAP_DR: step = m ? stap_pkg::ST_EXIT1_DR : stap_pkg::ST_SHIFT_DR;
			stap_pkg::ST_SHIFT_DR: step = m ? stap_pkg::ST_EXIT1_DR : stap_pkg::ST_SHIFT_DR;
			stap_pkg::ST_EXIT1_DR: step = m ? stap_pkg::ST_UPD_DR : stap_pkg::ST_PAUSE_DR;
			stap_pkg::ST_PAUSE_DR: step = m ? stap_pkg::ST_EXIT2_DR : stap_pkg::ST_PAUSE_DR;
			stap_pkg::ST_EXIT2_DR: step = m ? stap_pkg::ST_UPD_DR : stap_pkg::ST_SHIFT_DR;
			stap_pkg::ST_UPD_DR: step = m ? stap_pkg::ST_SEL_DR : stap_pkg::ST_RTI;
			stap_pkg::ST_SEL_IR: step = m ? stap_pkg::ST_TLR : stap_pkg::ST_CAP_IR;
			stap_pkg::ST_CAP_IR: step = m ? stap_pkg::ST_EXIT1_IR : stap_pkg::ST_SHIFT_IR;
			stap_pkg::ST_SHIFT_IR: step = m ? stap_pkg::ST_EXIT1_IR : stap_pkg::ST_SHIFT_IR;
			stap_pkg::ST_EXIT1_IR: step = m ? stap_pkg::ST_UPD_IR : stap_pkg::ST_PAUSE_IR;
			stap_pkg::ST_PAUSE_IR: step = m ? stap_pkg::ST_EXIT2_IR : stap_pkg::ST_PAUSE_IR;
			stap_pkg::ST_EXIT2_IR: step = m ? stap_pkg::ST_UPD_IR : stap_pkg::ST_SHIFT_IR;
			stap_pkg::ST_UPD_IR: step = m ? stap_pkg::ST_SEL_DR : stap_pkg::ST_RTI;
		endcase
	endfunction

	stap_pkg::stap_state_t st_ff;
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			st_ff <= stap_pkg::ST_TLR;
		end else if (tck_rise) begin
			st_ff <= step(st_ff, pin_s2_ff.tms);
		end
	end

	// ----------------------------------------
	// Instruction register
	// ----------------------------------------
	logic [`STAP_IR_W-1:0] ir_ff, ir_sh_ff;
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			ir_sh_ff <= `STAP_IR_IDCODE;
		end else if (tck_rise && st_ff == stap_pkg::ST_CAP_IR) begin
			ir_sh_ff <= {1'b0, `STAP_IR_CAPTURE};
		end else if (tck_rise && st_ff == stap_pkg::ST_SHIFT_IR) begin
			ir_sh_ff <= {pin_s2_ff.tdi, ir_sh_ff[`STAP_IR_W-1:1]};
		end
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			ir_ff <= `STAP_IR_IDCODE;
		end else if (tck_rise && st_ff == stap_pkg::ST_TLR) begin
			ir_ff <= `STAP_IR_IDCODE;
		end else if (tck_rise && st_ff == stap_pkg::ST_UPD_IR) begin
			ir_ff <= ir_sh_ff;
		end
	end

	// Reserved codes fall back to the bypass path so the chain stays intact.
	function automatic stap_pkg::stap_sel_t pick(input logic [`STAP_IR_W-1:0] code);
		unique case (code)
			`STAP_IR_IDCODE: pick = stap_pkg::SEL_ID;
			`STAP_IR_EXTEST, `STAP_IR_SAMPLEZ, `STAP_IR_SAMPLE: pick = stap_pkg::SEL_BSR;
			default: pick = stap_pkg::SEL_BYP;
		endcase
	endfunction

	stap_pkg::stap_sel_t sel;
	assign sel = pick(ir_ff);

	// ----------------------------------------
	// Data registers
	// ----------------------------------------
	logic [`STAP_BSR_W-1:0] bsr_ff;
	logic [`STAP_ID_W-1:0] id_ff;
	logic byp_ff;
	logic cap_dr, sh_dr;
	assign cap_dr = tck_rise && st_ff == stap_pkg::ST_CAP_DR;
	assign sh_dr = tck_rise && st_ff == stap_pkg::ST_SHIFT_DR;

	// Capture is not synchronised to the memory clock; a moving pin may be caught mid-change.
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			bsr_ff <= '0;
		end else if (cap_dr && sel == stap_pkg::SEL_BSR) begin
			bsr_ff <= bsr_capture;
		end else if (sh_dr && sel == stap_pkg::SEL_BSR) begin
			bsr_ff <= {pin_s2_ff.tdi, bsr_ff[`STAP_BSR_W-1:1]};
		end
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			id_ff <= '0;
		end else if (cap_dr && sel == stap_pkg::SEL_ID) begin
			id_ff <= ID_CODE;
		end else if (sh_dr && sel == stap_pkg::SEL_ID) begin
			id_ff <= {pin_s2_ff.tdi, id_ff[`STAP_ID_W-1:1]};
		end
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			byp_ff <= 1'b0;
		end else if (cap_dr && sel == stap_pkg::SEL_BYP) begin
			byp_ff <= 1'b0;
		end else if (sh_dr && sel == stap_pkg::SEL_BYP) begin
			byp_ff <= pin_s2_ff.tdi;
		end
	end

	// ----------------------------------------
	// Falling-edge outputs
	// ----------------------------------------
	logic lsb_out;
	always_comb begin
		unique case (sel)
			stap_pkg::SEL_BSR: lsb_out = bsr_ff[0];
			stap_pkg::SEL_ID: lsb_out = id_ff[0];
			default: lsb_out = byp_ff;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
			out_hiz <= 1'b0;
		end else if (tck_fall) begin
			tdo <= (st_ff == stap_pkg::ST_SHIFT_IR) ? ir_sh_ff[0] : lsb_out;
			tdo_oe <= st_ff == stap_pkg::ST_SHIFT_IR ||
				st_ff == stap_pkg::ST_SHIFT_DR;
			out_hiz <= ir_ff == `STAP_IR_EXTEST || ir_ff == `STAP_IR_SAMPLEZ;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [2:0] hi_cnt_ff;
	always_ff @(posedge clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			hi_cnt_ff <= '0;
		end else if (tck_rise) begin
			hi_cnt_ff <= !pin_s2_ff.tms ? 3'h0 :
				(hi_cnt_ff == `STAP_RESET_EDGES) ? hi_cnt_ff : hi_cnt_ff + 3'h1;
		end
	end

	tap_reset_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
		hi_cnt_ff == `STAP_RESET_EDGES |-> st_ff == stap_pkg::ST_TLR)
		else $error("Controller not in reset after five high edges.");
	state_hold_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
		!tck_rise |=> $stable(st_ff))
		else $error("Controller moved without a rising test clock.");
	tdo_fall_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
		!tck_fall |=> $stable(tdo) && $stable(tdo_oe))
		else $error("Data out changed without a falling test clock.");
	tdo_hiz_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
		tck_fall && st_ff != stap_pkg::ST_SHIFT_DR && st_ff != stap_pkg::ST_SHIFT_IR
		|=> !tdo_oe)
		else $error("Data out driven outside a shift state.");
	ir_capture_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
		tck_rise && st_ff == stap_pkg::ST_CAP_IR |=> ir_sh_ff[1:0] == `STAP_IR_CAPTURE)
		else $error("Instruction capture pattern wrong.");
	ir_update_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
		!(tck_rise && (st_ff == stap_pkg::ST_UPD_IR || st_ff == stap_pkg::ST_TLR))
		|=> $stable(ir_ff))
		else $error("Instruction changed outside update.");
	ir_reset_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
		tck_rise && st_ff == stap_pkg::ST_TLR |=> ir_ff == `STAP_IR_IDCODE)
		else $error("Instruction not identification after reset.");
	msb_entry_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
		sh_dr && sel == stap_pkg::SEL_ID |=> id_ff[`STAP_ID_W-1] == $past(pin_s2_ff.tdi))
		else $error("Serial data did not enter at the top bit.");
	lsb_out_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
		tck_fall && st_ff == stap_pkg::ST_SHIFT_IR |=> tdo == $past(ir_sh_ff[0]) && tdo_oe)
		else $error("Data out not from the low bit.");
	pull_up_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
		!tms_driven [*3] |-> pin_s2_ff.tms)
		else $error("Floating mode select did not read high.");

	reset_seq_c: cover property (@(posedge clk) disable iff (!rst_n_ff)
		hi_cnt_ff == `STAP_RESET_EDGES);
	ir_load_c: cover property (@(posedge clk) disable iff (!rst_n_ff)
		tck_rise && st_ff == stap_pkg::ST_UPD_IR && ir_sh_ff == `STAP_IR_BYPASS);
	id_shift_c: cover property (@(posedge clk) disable iff (!rst_n_ff)
		sh_dr && sel == stap_pkg::SEL_ID);

endmodule

`default_nettype wire

//--- logic/stap_regs.svh
// Constants for the serial test access port front end.
// Assumes inclusion by bare name from the top module.
`ifndef STAP_REGS_SVH
`define STAP_REGS_SVH

`define STAP_IR_W 3
`define STAP_IR_EXTEST 3'h0
`define STAP_IR_IDCODE 3'h1
`define STAP_IR_SAMPLEZ 3'h2
`define STAP_IR_SAMPLE 3'h4
`define STAP_IR_BYPASS 3'h7
`define STAP_IR_CAPTURE 2'h1
`define STAP_BSR_W 70
`define STAP_ID_W 32
`define STAP_RESET_EDGES 3'h5

`endif

//--- logic/stap_pkg.sv
// Types shared by the serial test access port front end.
// Assumes the constants header is on the include path.
`default_nettype none

package stap_pkg;

	// ----------------------------------------
	// Pin bundle and controller states
	// ----------------------------------------
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} stap_pins_t;

	typedef enum logic [3:0] {
		ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
		ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
		ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} stap_state_t;

	typedef enum logic [1:0] {
		SEL_BSR, SEL_ID, SEL_BYP
	} stap_sel_t;

endpackage

`default_nettype wire

//--- verification/stap_ctl_model.sv
// Boundary-scan controller model that drives the test port pins.
// Assumes clk is the bench clock; tck moves only inside the tasks.
`default_nettype none
module stap_ctl_model (
	input wire logic clk,
	input wire logic tdo,
	input wire logic tdo_oe,
	output var stap_pkg::stap_pins_t pins,
	output logic tms_driven,
	output logic tdi_driven
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		pins = '0;
		tms_driven = 1'b1;
		tdi_driven = 1'b1;
	end
	// A released line toggles every bit, so only a real pull-up reads steady high.
	task automatic step(input logic ms, input logic di, output logic q, output logic oe);
		@(negedge clk);
		pins.tms = tms_driven ? ms : ~pins.tms;
		pins.tdi = tdi_driven ? di : ~pins.tdi;
		repeat (4) @(negedge clk);
		// An undriven data out line has no pull, so the model reads it as the inverse.
		q = tdo_oe ? tdo : ~tdo;
		oe = tdo_oe;
		pins.tck = 1'b1;
		repeat (8) @(negedge clk);
		pins.tck = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic set_float(input logic ms_off, input logic di_off);
		tms_driven = ~ms_off;
		tdi_driven = ~di_off;
	endtask
	task automatic moves(input logic [7:0] seq, input int n);
		logic q;
		logic oe;
		for (int i = 0; i < n; i++) step(seq[i], 1'b1, q, oe);
	endtask
	// Shifts n bits, then leaves through Exit1 and Update to Idle.
	task automatic shift(input int n, input logic [69:0] din, output logic [69:0] dout,
		output logic oe_all);
		logic q;
		logic oe;
		dout = '0;
		oe_all = 1'b1;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q, oe);
			dout[i] = q;
			oe_all &= oe;
		end
		moves(8'h01, 2);
	endtask
endmodule
`default_nettype wire

//--- verification/test_sram_test_access_port_front.sv
// Self-checking bench for the test access port front end.
// Assumes the controller model makes all pin traffic at a 160 ns test clock.
`default_nettype none
module test_sram_test_access_port_front;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ID = 32'h5a3c_96e1; // Arbitrary value.
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [69:0] bsr = 70'h2_a5a5_c3c3_0ff0_1234_5;
	stap_pkg::stap_pins_t pins;
	logic tms_drv, tdi_drv, tdo, tdo_oe, out_hiz;
	int error_cnt = 0;
	int checked = 0;
	always #5 clk = ~clk;
	stap_top #(.ID_CODE(ID)) DUT (.clk(clk), .nrst(nrst), .pins(pins), .tms_driven(tms_drv),
		.tdi_driven(tdi_drv), .bsr_capture(bsr), .tdo(tdo), .tdo_oe(tdo_oe), .out_hiz(out_hiz));
	stap_ctl_model ctl (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .pins(pins),
		.tms_driven(tms_drv), .tdi_driven(tdi_drv));
	task automatic chk(input logic [69:0] got, input logic [69:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("mismatches %0d, comparisons %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic load_ir(input logic [2:0] code);
		logic [69:0] q;
		logic oe;
		ctl.moves(8'h03, 4);
		ctl.shift(3, {67'h0, code}, q, oe);
		chk(q, 70'h1, "instruction capture");
		chk(70'(oe), 70'h1, "drive in shift");
		chk(70'(tdo_oe), 70'h0, "release in idle");
	endtask
	task automatic read_dr(input int n, input logic [69:0] din, output logic [69:0] q);
		logic oe;
		ctl.moves(8'h01, 3);
		ctl.shift(n, din, q, oe);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_power();
		logic [69:0] q;
		chk(70'({tdo_oe, out_hiz}), 70'h0, "power-up outputs");
		ctl.moves(8'h00, 1);
		read_dr(32, 70'h0, q);
		chk(q, 70'(ID), "id after power-up");
	endtask
	task automatic t_bypass();
		logic [69:0] q;
		load_ir(3'h7);
		read_dr(8, 70'hb4, q);
		chk(q, 70'h68, "bypass one-bit delay");
		ctl.set_float(1'b0, 1'b1);
		read_dr(8, 70'h0, q);
		ctl.set_float(1'b0, 1'b0);
		chk(q, 70'hfe, "data in pull-up");
	endtask
	task automatic t_scan();
		logic [69:0] q;
		logic [2:0] codes[5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h7};
		logic [4:0] hiz = 5'h03;
		load_ir(3'h4);
		read_dr(70, ~bsr, q);
		chk(q, bsr, "ring snapshot");
		for (int i = 0; i < 5; i++) begin
			load_ir(codes[i]);
			chk(70'(out_hiz), 70'(hiz[i]), "outputs high-z");
		end
	endtask
	task automatic t_reset();
		logic [69:0] q;
		load_ir(3'h0);
		ctl.set_float(1'b1, 1'b0);
		ctl.moves(8'h00, 5);
		ctl.set_float(1'b0, 1'b0);
		ctl.moves(8'h00, 1);
		chk(70'(out_hiz), 70'h0, "high-z cleared");
		read_dr(32, 70'h0, q);
		chk(q, 70'(ID), "id after port reset");
	endtask
	initial begin
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		t_power();
		t_bypass();
		t_scan();
		t_reset();
		report_and_stop();
	end
	initial begin
		repeat (50000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
endmodule
`default_nettype wire
